// >>> hw/nbs_pkg.sv
// package for the bridge window setup and translation register bank
package nbs_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_W2_XLATE = 12'h090;
	localparam logic [11:0] OFS_W3_CFG = 12'h094;
	localparam logic [11:0] OFS_W2_CFG = 12'h08c;
	localparam logic [11:0] OFS_W1_XLATE = 12'h088;
	// setup and translation register field positions
	localparam int SPACE_BIT = 0;
	localparam int ATYPE_LO = 1;
	localparam int PREFETCH_SELECT_BIT = 3;
	localparam int SIZE_LO = 4;
	localparam int SIZE_HI = 9;
	localparam int EN_BIT = 31;
	localparam int XLATE_LO = 4;
	// address type codes
	localparam logic [1:0] ATYPE_32 = 2'h0;
	localparam logic [1:0] ATYPE_64 = 2'h2;
	// power-up values
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] XLATE_RESET = 32'h0000_0000;
	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// setup register fields
	typedef struct packed {
		logic enable;
		logic [20:0] rsvd;
		logic [5:0] size;
		logic prefetch_select;
		logic [1:0] addr_type;
		logic space_kind_select;
	} nbs_cfg_t;

	// window description handed to the translation datapath
	typedef struct packed {
		logic enable;
		logic space_io;
		logic is64;
		logic prefetch;
		logic [63:0] xlated_base;
	} nbs_win_t;
endpackage

// >>> hw/nbs_regs.sv
// bridge window setup and translated base registers behind an axi4-lite slave
// Function
// - cleared enable bit disables the window and zeroes its window output
// - setup and translated base survive hot and fundamental reset, zero at power-up
// - window 2 translated base is bits 31:4, low four bits read zero
// - 64-bit window 2 base takes upper 32 bits from window 1 translated base
// - memory plus 64-bit window 2 turns window 3 off, its window output zero
// - window 3 setup reads zero and ignores writes while window 2 is 64-bit
// - window 3 space select: 0 memory, 1 i/o
// - address type forced zero when space select says i/o
// - window 3 address type supports only 32-bit code zero
// - prefetch select: 0 non-prefetchable, 1 prefetchable
// - window 2 address type 2 means 64-bit, 0 means 32-bit
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module nbs_regs #(
	parameter int ADDR_W = 12
) (
	// clock and resets
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic npwr_on_rst_in,
	input wire logic hot_rst_in,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// window state for the translation datapath
	output nbs_pkg::nbs_win_t win2_out,
	output nbs_pkg::nbs_win_t win3_out
);
	// refuse address widths too narrow for the register map
	if (ADDR_W < 12) begin : g_addr_w_check
		$error("nbs_regs: ADDR_W must be at least 12");
	end

	// reset release synchroniser
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// stored configuration
	nbs_pkg::nbs_cfg_t w2_cfg_q, w2_cfg_d, w3_cfg_q, w3_cfg_d;
	logic [31:0] w1_xl_q, w1_xl_d, w2_xl_q, w2_xl_d;
	// bus state
	logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
	logic awready_q, wready_q;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic rvalid_q, rvalid_d, arready_q, arready_d;
	logic [31:0] rdata_q, rdata_d;
	nbs_pkg::nbs_win_t win2_q, win2_d, win3_q, win3_d;

	// window 2 decodes as 64-bit memory
	logic w2_is64;
	assign w2_is64 = !w2_cfg_q.space_kind_select &&
		(w2_cfg_q.addr_type == nbs_pkg::ATYPE_64);

	// byte-lane merge
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// legalise a setup value before storing it
	function automatic nbs_pkg::nbs_cfg_t legal_cfg(input logic [31:0] v, input logic only32);
		nbs_pkg::nbs_cfg_t c;
		c = nbs_pkg::nbs_cfg_t'(v);
		c.rsvd = '0;
		if (c.space_kind_select) begin
			c.addr_type = nbs_pkg::ATYPE_32;
		end
		if (only32) begin
			c.addr_type = nbs_pkg::ATYPE_32;
		end else if (c.addr_type[0]) begin
			c.addr_type = nbs_pkg::ATYPE_32;
		end
		return c;
	endfunction

	// write channel and register updates
	logic wr_fire;
	logic [31:0] wr_val;
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		w1_xl_d = w1_xl_q;
		w2_xl_d = w2_xl_q;
		w2_cfg_d = w2_cfg_q;
		w3_cfg_d = w3_cfg_q;
		wr_val = 32'h0000_0000;
		if (s_axi_awvalid_in && awready_q) begin // taken only while ready shows
			aw_got_d = 1'b1;
			awaddr_d = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && wready_q) begin // taken only while ready shows
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata_in;
			wstrb_d = s_axi_wstrb_in;
		end
		if (wr_fire) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = nbs_pkg::RESP_OKAY;
			unique case (awaddr_q[11:0])
				nbs_pkg::OFS_W1_XLATE: begin
					wr_val = merge(w1_xl_q, wdata_q, wstrb_q);
					w1_xl_d = {wr_val[31:nbs_pkg::XLATE_LO], 4'h0};
				end
				nbs_pkg::OFS_W2_XLATE: begin
					wr_val = merge(w2_xl_q, wdata_q, wstrb_q);
					w2_xl_d = {wr_val[31:nbs_pkg::XLATE_LO], 4'h0};
				end
				nbs_pkg::OFS_W2_CFG: begin
					wr_val = merge(w2_cfg_q, wdata_q, wstrb_q);
					w2_cfg_d = legal_cfg(wr_val, 1'b0);
				end
				nbs_pkg::OFS_W3_CFG: begin
					wr_val = merge(w3_cfg_q, wdata_q, wstrb_q);
					if (!w2_is64) begin
						w3_cfg_d = legal_cfg(wr_val, 1'b1);
					end
				end
				default: begin
					bresp_d = nbs_pkg::RESP_SLVERR;
				end
			endcase
			if ((awaddr_q >> 12) != '0) begin
				bresp_d = nbs_pkg::RESP_SLVERR;
			end
		end
		if (bvalid_q && s_axi_bready_in) begin
			bvalid_d = 1'b0;
		end
	end

	// read channel
	always_comb begin
		arready_d = 1'b0;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready_in) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid_in && !rvalid_q && !arready_q) begin
			arready_d = 1'b1;
			rvalid_d = 1'b1;
			rresp_d = nbs_pkg::RESP_OKAY;
			unique case (s_axi_araddr_in[11:0])
				nbs_pkg::OFS_W1_XLATE: rdata_d = w1_xl_q;
				nbs_pkg::OFS_W2_XLATE: rdata_d = w2_xl_q;
				nbs_pkg::OFS_W2_CFG: rdata_d = w2_cfg_q;
				nbs_pkg::OFS_W3_CFG: rdata_d = w2_is64 ? 32'h0000_0000 : w3_cfg_q;
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = nbs_pkg::RESP_SLVERR;
				end
			endcase
			if ((s_axi_araddr_in >> 12) != '0) begin
				rdata_d = 32'h0000_0000;
				rresp_d = nbs_pkg::RESP_SLVERR;
			end
		end
	end

	// window outputs for the translation datapath
	always_comb begin
		win2_d = '0;
		win3_d = '0;
		if (w2_cfg_q.enable) begin
			win2_d.enable = 1'b1;
			win2_d.space_io = w2_cfg_q.space_kind_select;
			win2_d.is64 = w2_is64;
			win2_d.prefetch = w2_cfg_q.prefetch_select;
			win2_d.xlated_base = {w2_is64 ? w1_xl_q : 32'h0000_0000, w2_xl_q};
		end
		if (w3_cfg_q.enable && !w2_is64) begin
			win3_d.enable = 1'b1;
			win3_d.space_io = w3_cfg_q.space_kind_select;
			win3_d.prefetch = w3_cfg_q.prefetch_select;
		end
	end

	// configuration keeps its value over hot and fundamental reset
	always_ff @(posedge clk_in or negedge npwr_on_rst_in) begin
		if (!npwr_on_rst_in) begin
			w1_xl_q <= nbs_pkg::XLATE_RESET;
			w2_xl_q <= nbs_pkg::XLATE_RESET;
			w2_cfg_q <= nbs_pkg::CFG_RESET;
			w3_cfg_q <= nbs_pkg::CFG_RESET;
		end else begin
			w1_xl_q <= w1_xl_d;
			w2_xl_q <= w2_xl_d;
			w2_cfg_q <= w2_cfg_d;
			w3_cfg_q <= w3_cfg_d;
		end
	end

	// bus and output registers follow the ordinary reset
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
			win2_q <= '0;
			win3_q <= '0;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			win2_q <= win2_d;
			win3_q <= win3_d;
		end
	end

	// hot reset is accepted but leaves the configuration alone
	logic hot_seen_q;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			hot_seen_q <= 1'b0;
		end else begin
			hot_seen_q <= hot_rst_in;
		end
	end

	// ready flags are flops: space free for a new beat, low during reset
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end else begin
			awready_q <= !aw_got_d;
			wready_q <= !w_got_d;
		end
	end

	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;
	assign win2_out = win2_q;
	assign win3_out = win3_q;
endmodule

// >>> tb/nbs_regs_sva.sv
// concurrent checks on the window register bank ports
`timescale 1ns/1ps
module nbs_regs_sva (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// bus handshakes
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// window state
	input wire nbs_pkg::nbs_win_t win2_out,
	input wire nbs_pkg::nbs_win_t win3_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// read address taken together with the data
	sequence s_rd_take;
		s_axi_arready_out && s_axi_rvalid_out;
	endsequence
	// answers stand until taken
	a_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write answer dropped");
	a_r_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read answer dropped");
	a_rd_pulse: assert property (s_axi_arready_out |-> s_rd_take ##1 !s_axi_arready_out)
		else $error("read accept malformed");
	// window outputs
	a_w2_off: assert property (!win2_out.enable |-> win2_out == '0)
		else $error("window 2 live while off");
	a_w3_off: assert property (!win3_out.enable |-> win3_out == '0)
		else $error("window 3 live while off");
	a_w3_shadow: assert property (win2_out.enable && win2_out.is64 |-> win3_out == '0)
		else $error("window 3 live beside wide window 2");
	a_low_zero: assert property (win2_out.xlated_base[3:0] == 4'h0)
		else $error("base low bits set");
	a_w3_narrow: assert property (!win3_out.is64 && win3_out.xlated_base == 64'h0)
		else $error("window 3 wide");
	a_io_narrow: assert property (win2_out.space_io |-> !win2_out.is64)
		else $error("i/o window wide");
endmodule
bind nbs_regs nbs_regs_sva i_sva (.clk_in, .nrst_in, .s_axi_arready_out, .s_axi_rvalid_out,
	.s_axi_rready_in, .s_axi_rdata_out, .s_axi_bvalid_out, .s_axi_bready_in, .win2_out,
	.win3_out);

// >>> tb/test_nbs_regs.sv
// self-checking bench for the window register bank
`timescale 1ns/1ps
module test_nbs_regs;
	logic clk = 0, nrst = 0, npor = 0, hot = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic awr, wr, bv, arr, rv;
	logic [11:0] awa = 12'h0, ara = 12'h0;
	logic [31:0] wd = 32'h0, rd;
	logic [3:0] ws = 4'h0;
	logic [1:0] bres, rres;
	nbs_pkg::nbs_win_t w2, w3, e2, e3;
	logic [31:0] m [5] = '{default: 32'h0};
	logic [11:0] adr [5] = '{nbs_pkg::OFS_W1_XLATE, nbs_pkg::OFS_W2_CFG,
		nbs_pkg::OFS_W2_XLATE, nbs_pkg::OFS_W3_CFG, 12'h0a0};
	int bad_count = 0, compares = 0, n;
	// clock
	always #2.5 clk = ~clk;
	// design
	nbs_regs i_dut (.clk_in(clk), .nrst_in(nrst), .npwr_on_rst_in(npor), .hot_rst_in(hot),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
		.s_axi_bresp_out(bres), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rd), .s_axi_rresp_out(rres), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rr), .win2_out(w2), .win3_out(w3));
	// compare and count
	task automatic chk(input logic [67:0] seen, input logic [67:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// counts and verdict
	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// bounded wait ran out
	task automatic guard;
		if (n >= 40) begin
			bad_count++;
			$display("[ERR] %0t no answer", $time);
			summarize();
		end
	endtask
	// stored form of a written word
	function automatic logic [31:0] fix(input int i, input logic [31:0] v);
		if (i == 0)
			return v & 32'hffff_fff0;
		if (i == 2)
			return v & 32'hffff_fff0;
		v = v & 32'h8000_03ff;
		if (v[0] || i == 3 || v[2:1] != nbs_pkg::ATYPE_64)
			v[2:1] = nbs_pkg::ATYPE_32;
		return v;
	endfunction
	// random write with random lanes
	task automatic put(input int i);
		logic [31:0] d, bm;
		d = $urandom;
		bm = 32'h0;
		@(posedge clk);
		awa <= adr[i];
		wd <= d;
		ws <= 4'($urandom);
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (n = 0; n < 40 && !(bv && br); n++) begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end
		br <= 1'b0;
		guard();
		chk(bres, i == 4 ? nbs_pkg::RESP_SLVERR : nbs_pkg::RESP_OKAY);
		for (int k = 0; k < 4; k++)
			if (ws[k])
				bm[8*k+:8] = 8'hff;
		if (i < 4 && !(i == 3 && m[1][2]))
			m[i] = fix(i, m[i] & ~bm | d & bm);
	endtask
	// read one register, compare it and the windows
	task automatic probe(input int i);
		@(posedge clk);
		ara <= adr[i];
		arv <= 1'b1;
		rr <= 1'b1;
		for (n = 0; n < 40 && !(rv && rr); n++)
			@(posedge clk);
		arv <= 1'b0;
		rr <= 1'b0;
		guard();
		chk(rd, i == 4 || i == 3 && m[1][2] ? 32'h0 : m[i]);
		chk(rres, i == 4 ? nbs_pkg::RESP_SLVERR : nbs_pkg::RESP_OKAY);
		e2 = '0;
		e3 = '0;
		if (m[1][31])
			e2 = {1'b1, m[1][0], m[1][2], m[1][3], m[1][2] ? m[0] : 32'h0, m[2]};
		if (m[3][31] && !m[1][2])
			e3 = {1'b1, m[3][0], 1'b0, m[3][3], 64'h0};
		chk(w2, e2);
		chk(w3, e3);
	endtask
	// main sequence
	initial begin
		void'($urandom(32'h7eab9af7));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		npor <= 1'b1;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 5; i++)
			probe(i);
		$display("test power-up done");
		repeat (300) begin
			hot <= 1'($urandom);
			put($urandom_range(4, 0));
			for (int i = 0; i < 5; i++)
				probe(i);
		end
		$display("test random writes done");
		nrst <= 1'b0;
		hot <= 1'b1;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 5; i++)
			probe(i);
		$display("test hot reset done");
		npor <= 1'b0;
		@(posedge clk);
		npor <= 1'b1;
		m = '{default: 32'h0};
		for (int i = 0; i < 5; i++)
			probe(i);
		$display("test power reset done");
		summarize();
	end
endmodule
